// *** design/suspend_power_down_control_defines.svh ***
/*
  Offsets, field positions, reset values and timing figures of the
  power-down control block.
  Assumes inclusion by bare name from the design file.
*/
`ifndef SUSPEND_POWER_DOWN_CONTROL_DEFINES_SVH
`define SUSPEND_POWER_DOWN_CONTROL_DEFINES_SVH

`define PDC_OFFSET      16'h0354
`define PDC_RESET       32'h03E8_1BA0
`define TMO_RESET_32    16'h03E8
`define TMO_RESET_16    16'h17E8
`define TMO_FORCED_16   16'h1400
`define TMO_MAX         16'hFFFF
`define TMO_MSB         31
`define TMO_LSB         16
`define PD3_BIT         12
`define PD2_BIT         11
`define VBAT_BIT        10
`define BIAS_BIT        5
`define VREG_BIT        4
`define OC1_BIT         1
`define KEEP_BIT        0
`define SLOW_PERIOD_US  10
`define MAX_WAKE_MS     500

`endif

// *** design/suspend_power_down_control_pkg.sv ***
/*
  Types of the power-down control block: power state and gating outputs.
  Assumes nothing of its surroundings.
*/
package suspend_power_down_control_pkg;

  typedef enum logic [1:0]
  {
    ST_RUN  = 2'b00,
    ST_SUSP = 2'b01,
    ST_WAKE = 2'b11
  } pm_state_t;

  typedef struct packed
  {
    logic       port3_pulldown_en;
    logic       port2_pulldown_en;
    logic       battery_detector_power_off;
    logic       bias_power_in_suspend;
    logic       regulator_low_power;
    logic [3:1] overcurrent_power_off;
    logic       clocks_run;
  } gating_t;

endpackage : suspend_power_down_control_pkg

// *** design/suspend_power_down_control.sv ***
/*
  Power-down control register and suspend wake-up timeout.
  Assumes a simple processor port synchronous to CLK, a slow clock
  sampled as a synchronous input, and a bus-width strap stable at reset.
*/
`timescale 1ns/100ps
`include "suspend_power_down_control_defines.svh"

module suspend_power_down_control
  import suspend_power_down_control_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST_B,
  input  wire logic        BUS_16BIT,
  input  wire logic [15:0] ADDR,
  input  wire logic        WR_EN,
  input  wire logic        RD_EN,
  input  wire logic [1:0]  HALF_EN,
  input  wire logic [31:0] WDATA,
  output logic      [31:0] RDATA,
  input  wire logic        SLOW_CLK,
  input  wire logic        SUSPEND_CMD,
  input  wire logic        WAKE_EVENT,
  input  wire logic        NORMAL_MODE,
  input  wire logic        CLOCKS_LOCKED,
  output logic             IN_SUSPEND,
  output logic             CLOCKS_STABLE_IRQ,
  output gating_t          GATING
);

  function automatic logic is_reg_addr(input logic [15:0] a);
    is_reg_addr = (a == `PDC_OFFSET);
  endfunction : is_reg_addr

  logic [31:0] ctrl_reg;
  logic [15:0] ctrl_lo_reg;
  logic [15:0] ctrl_hi_reg;
  logic [31:0] rdata_reg;
  logic [15:0] cnt_reg;
  logic        init_done_reg;
  logic        slow_prev_reg;
  logic        stopped_reg;
  logic        wait_lock_reg;
  logic        irq_reg;
  pm_state_t   state_reg;
  pm_state_t   state_next;
  logic [15:0] tmo;
  logic        wr_hit;
  logic        tick;
  logic        keep;
  logic        in_susp;
  wire logic [3:1] oc_off;

  assign ctrl_reg = {ctrl_hi_reg, ctrl_lo_reg};
  assign tmo     = ctrl_reg[`TMO_MSB:`TMO_LSB];
  assign wr_hit  = WR_EN && is_reg_addr(ADDR);
  assign tick    = SLOW_CLK && !slow_prev_reg;
  assign keep    = ctrl_reg[`KEEP_BIT];
  assign in_susp = (state_reg == ST_SUSP);

  // strap captured at the first edge after release
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      init_done_reg <= 1'b0;
    else
      init_done_reg <= 1'b1;
  end

  // low half: pull-downs, gating bits, reserved bits kept as written
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      ctrl_lo_reg <= 16'(`PDC_RESET);
    else if (wr_hit && HALF_EN[0])
      ctrl_lo_reg <= WDATA[15:0];
  end

  // timeout field
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      ctrl_hi_reg <= `TMO_RESET_32;
    else if (!init_done_reg)
    begin
      if (BUS_16BIT)
        ctrl_hi_reg <= `TMO_RESET_16;
    end
    else if (wr_hit && HALF_EN[1])
      ctrl_hi_reg <= BUS_16BIT ? `TMO_FORCED_16 : WDATA[31:16];
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      rdata_reg <= 32'h0000_0000;
    else if (RD_EN)
      rdata_reg <= is_reg_addr(ADDR) ? ctrl_reg : 32'h0000_0000;
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      slow_prev_reg <= 1'b0;
    else
      slow_prev_reg <= SLOW_CLK;
  end

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_RUN:
        if (SUSPEND_CMD)
          state_next = ST_SUSP;
      ST_SUSP:
        if (WAKE_EVENT && tmo != 16'h0000)
          state_next = ST_WAKE;
      ST_WAKE:
        if (NORMAL_MODE)
          state_next = ST_RUN;
        else if (!WAKE_EVENT && cnt_reg == 16'h0000)
          state_next = ST_SUSP;
      default:
        state_next = ST_RUN;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      state_reg <= ST_RUN;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      cnt_reg <= 16'h0000;
    else if (WAKE_EVENT && state_reg != ST_RUN)
      cnt_reg <= tmo;
    else if (state_reg == ST_WAKE && tick && cnt_reg != 16'h0000)
      cnt_reg <= cnt_reg - 16'h0001;
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      stopped_reg   <= 1'b0;
      wait_lock_reg <= 1'b0;
      irq_reg       <= 1'b0;
    end
    else
    begin
      irq_reg <= 1'b0;
      if (in_susp)
        stopped_reg <= stopped_reg || !keep;
      else
        stopped_reg <= 1'b0;
      if (in_susp && state_next != ST_SUSP && (stopped_reg || !keep))
        wait_lock_reg <= 1'b1;
      else if (wait_lock_reg && CLOCKS_LOCKED)
      begin
        wait_lock_reg <= 1'b0;
        irq_reg       <= 1'b1;
      end
    end
  end

  genvar g;
  generate
    for (g = 1; g <= 3; g++)
    begin : g_oc
      assign oc_off[g] = in_susp && ctrl_reg[`OC1_BIT + g - 1];
    end
  endgenerate

  always_comb
  begin
    GATING.port3_pulldown_en          = ctrl_reg[`PD3_BIT];
    GATING.port2_pulldown_en          = ctrl_reg[`PD2_BIT];
    GATING.battery_detector_power_off = in_susp && ctrl_reg[`VBAT_BIT];
    GATING.bias_power_in_suspend      = !in_susp || ctrl_reg[`BIAS_BIT];
    GATING.regulator_low_power        = in_susp && ctrl_reg[`VREG_BIT];
    GATING.overcurrent_power_off      = oc_off;
    GATING.clocks_run                 = !in_susp || keep;
  end

  assign RDATA             = rdata_reg;
  assign IN_SUSPEND        = in_susp;
  assign CLOCKS_STABLE_IRQ = irq_reg;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);

  property p_load;
    state_reg == ST_SUSP && WAKE_EVENT && tmo != 16'h0000
      |=> state_reg == ST_WAKE && cnt_reg == $past(tmo);
  endproperty
  a_load: assert property (p_load) else $error("wake did not load");

  property p_zero;
    state_reg == ST_SUSP && tmo == 16'h0000 |=> state_reg == ST_SUSP;
  endproperty
  a_zero: assert property (p_zero) else $error("woke with zero timeout");

  property p_expire;
    state_reg == ST_WAKE && cnt_reg == 16'h0000 && !NORMAL_MODE && !WAKE_EVENT
      |=> state_reg == ST_SUSP;
  endproperty
  a_expire: assert property (p_expire) else $error("no suspend at expiry");

  property p_normal;
    state_reg == ST_WAKE && NORMAL_MODE |=> state_reg == ST_RUN;
  endproperty
  a_normal: assert property (p_normal) else $error("normal mode ignored");

  property p_tick;
    state_reg == ST_WAKE && !WAKE_EVENT && cnt_reg != 16'h0000
      |=> cnt_reg == $past(cnt_reg) - {15'h0, $past(tick)};
  endproperty
  a_tick: assert property (p_tick) else $error("count not per tick");

  property p_force16;
    init_done_reg && wr_hit && HALF_EN[1] && BUS_16BIT |=> tmo == `TMO_FORCED_16;
  endproperty
  a_force16: assert property (p_force16) else $error("16-bit write not forced");

  property p_init;
    !init_done_reg |=> tmo == (BUS_16BIT ? `TMO_RESET_16 : `TMO_RESET_32);
  endproperty
  a_init: assert property (p_init) else $error("bad timeout default");

  property p_pd;
    wr_hit && HALF_EN[0]
      |=> GATING.port3_pulldown_en == $past(WDATA[`PD3_BIT])
       && GATING.port2_pulldown_en == $past(WDATA[`PD2_BIT]);
  endproperty
  a_pd: assert property (p_pd) else $error("pull-down not updated");

  property p_clk;
    in_susp && !keep |-> !GATING.clocks_run;
  endproperty
  a_clk: assert property (p_clk) else $error("clocks run in suspend");

  property p_irq;
    wait_lock_reg && CLOCKS_LOCKED && !in_susp |=> CLOCKS_STABLE_IRQ ##1 !CLOCKS_STABLE_IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("clock-ready irq missing");

  property p_oc;
    !in_susp |-> GATING.overcurrent_power_off == 3'h0;
  endproperty
  a_oc: assert property (p_oc) else $error("overcurrent off outside suspend");

  property p_run_gates;
    !in_susp |-> GATING.clocks_run && GATING.bias_power_in_suspend
      && !GATING.battery_detector_power_off && !GATING.regulator_low_power;
  endproperty
  a_run_gates: assert property (p_run_gates) else $error("gating active in run");

  property p_irq_src;
    CLOCKS_STABLE_IRQ |-> $past(wait_lock_reg) && $past(CLOCKS_LOCKED);
  endproperty
  a_irq_src: assert property (p_irq_src) else $error("spurious clock-ready irq");

  property p_reload;
    state_reg == ST_WAKE && WAKE_EVENT |=> cnt_reg == $past(tmo) && state_reg != ST_SUSP;
  endproperty
  a_reload: assert property (p_reload) else $error("wake did not reload");

  c_wake: cover property (state_reg == ST_SUSP ##1 state_reg == ST_WAKE);
  c_expire: cover property (state_reg == ST_WAKE ##1 state_reg == ST_SUSP);
  c_normal: cover property (state_reg == ST_WAKE ##1 state_reg == ST_RUN);
  c_irq: cover property (CLOCKS_STABLE_IRQ);

endmodule : suspend_power_down_control

// *** bench/suspend_power_down_control_tb_top.sv ***
/*
  Self-checking bench for the power-down control block: register access,
  bus-width defaults, suspend/wake timeout and clock-ready pulse.
  Assumes the design and package under design/ and a 20 MHz CLK.
*/
`timescale 1ns/100ps
module suspend_power_down_control_tb_top
  import suspend_power_down_control_pkg::*;
;
  logic        clk;
  logic        rst_b;
  logic        bus_16bit;
  logic [15:0] addr;
  logic        wr_en;
  logic        rd_en;
  logic [1:0]  half_en;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        slow_clk;
  logic        suspend_cmd;
  logic        wake_event;
  logic        normal_mode;
  logic        clocks_locked;
  logic        in_suspend;
  logic        clocks_stable_irq;
  gating_t     gating;
  integer      err_total = 0;
  integer      compares  = 0;
  integer      seed      = 30;
  integer      n;
  logic [31:0] rd_val;
  logic [31:0] w;
  logic [15:0] tmo;

  suspend_power_down_control i_suspend_power_down_control (
    .CLK(clk), .RST_B(rst_b), .BUS_16BIT(bus_16bit), .ADDR(addr), .WR_EN(wr_en),
    .RD_EN(rd_en), .HALF_EN(half_en), .WDATA(wdata), .RDATA(rdata),
    .SLOW_CLK(slow_clk), .SUSPEND_CMD(suspend_cmd), .WAKE_EVENT(wake_event),
    .NORMAL_MODE(normal_mode), .CLOCKS_LOCKED(clocks_locked),
    .IN_SUSPEND(in_suspend), .CLOCKS_STABLE_IRQ(clocks_stable_irq), .GATING(gating)
  );

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares = compares + 1;
    if (got !== exp)
    begin
      err_total = err_total + 1;
      $display("[ERR] %0t got %08X expected %08X", $time, got, exp);
    end
  endtask : chk

  // register image with reserved bits kept at their reset values
  function automatic logic [31:0] mk(input logic [15:0] t, input logic [31:0] r);
    return {t, 3'h0, r[12:10], 4'hE, r[5:0]};
  endfunction : mk

  function automatic gating_t exp_gate(input logic [31:0] r, input logic s);
    return s ? {r[12], r[11], r[10], r[5], r[4], r[3:1], r[0]}
             : {r[12], r[11], 1'b0, 1'b1, 1'b0, 3'h0, 1'b1};
  endfunction : exp_gate

  task automatic do_reset(input logic m16);
    rst_b     <= 1'b0;
    bus_16bit <= m16;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
  endtask : do_reset

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(posedge clk);
    #1 rd_val = rdata;
  endtask : rd

  task automatic pulse(input int which);
    @(posedge clk);
    if (which == 0)
      suspend_cmd <= 1'b1;
    else
      wake_event <= 1'b1;
    @(posedge clk);
    suspend_cmd <= 1'b0;
    wake_event  <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : pulse

  task automatic ticks(input int k);
    repeat (k)
    begin
      @(posedge clk);
      slow_clk <= 1'b1;
      repeat (2) @(posedge clk);
      slow_clk <= 1'b0;
      repeat (2) @(posedge clk);
    end
    #1;
  endtask : ticks

  task automatic tend(input string name);
    $display("test %0s finished", name);
  endtask : tend

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  initial
  begin
    #1_000_000;
    err_total = err_total + 1;
    wrap_up();
  end

  initial
  begin
    {rst_b, bus_16bit, addr, wr_en, rd_en, wdata, slow_clk} = '0;
    {suspend_cmd, wake_event, normal_mode, clocks_locked} = '0;
    half_en = 2'h3;
    do_reset(1'b0);
    rd(16'h0354);
    chk(rd_val, 32'h03E8_1BA0);
    chk({23'h0, gating}, {23'h0, exp_gate(32'h03E8_1BA0, 1'b0)});
    tend("reset");
    for (n = 0; n < 5; n++)
    begin
      w = mk((n == 0) ? 16'hFFFF : 16'($random(seed)), 32'($random(seed)));
      wr(16'h0354, w);
      rd(16'h0354);
      chk(rd_val, w);
      rd(16'h0358);
      chk(rd_val, 32'h0);
    end
    half_en <= 2'h1;
    wr(16'h0354, mk(~w[31:16], ~w));
    rd(16'h0354);
    chk(rd_val, {w[31:16], 16'(mk(16'h0, ~w))});
    half_en <= 2'h3;
    tend("access");
    tmo = 16'd2 + 16'($random(seed) & 3);
    w   = mk(tmo, 32'($random(seed)) & 32'hFFFF_FFFE);
    wr(16'h0354, w);
    pulse(0);
    chk({31'h0, in_suspend}, 32'h1);
    chk({23'h0, gating}, {23'h0, exp_gate(w, 1'b1)});
    pulse(1);
    ticks(1);
    pulse(1);
    ticks(int'(tmo) - 1);
    chk({31'h0, in_suspend}, 32'h0);
    ticks(1);
    repeat (3) @(posedge clk);
    #1 chk({31'h0, in_suspend}, 32'h1);
    tend("timeout");
    pulse(1);
    normal_mode <= 1'b1;
    ticks(int'(tmo) + 1);
    chk({31'h0, in_suspend}, 32'h0);
    clocks_locked <= 1'b1;
    n = 0;
    repeat (6)
    begin
      @(posedge clk);
      #1 n = n + int'(clocks_stable_irq === 1'b1);
    end
    chk(32'(n), 32'h1);
    clocks_locked <= 1'b0;
    normal_mode   <= 1'b0;
    tend("normal");
    wr(16'h0354, mk(16'h0, w));
    pulse(0);
    @(posedge clk);
    wake_event <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk({31'h0, in_suspend}, 32'h1);
    wake_event <= 1'b0;
    tend("zero");
    do_reset(1'b1);
    rd(16'h0354);
    chk(rd_val, 32'h17E8_1BA0);
    w = mk(16'($random(seed)), 32'($random(seed)));
    wr(16'h0354, w);
    rd(16'h0354);
    chk(rd_val, {16'h1400, w[15:0]});
    tend("narrow");
    wrap_up();
  end
endmodule : suspend_power_down_control_tb_top
